// *** include/dso_pkg.sv ***
// constants, types and register map of the drive status output block
// Overview of operation
// - ready output on once hardware prepared and no protection active
// - code 21: delayed arrival after pre-limit frequency in band plus delay
// - code 22: limiting output only after limiting persists 20 ms or more
// - heat sink warning sets above trip minus 5, clears at minus 8
// - code 30: wear alarm when any capacitor or fan reaches end of life
// - code 33: reference loss output follows analog loss state
// - code 35: output-on while running at or below start frequency or DC braking
// - code 36: overload prevention output held on at least 100 ms
// - codes 37/38: current detect when current above level longer than timer
// - current detect clears when current below 90 percent of its level
// - current detect stays on at least 100 ms once asserted
// - two current detect channels, each with own level and timer
// - code 49: second motor output while motor 2 is selected
// - code 57: terminal carries the brake release command
// - code 99: any-alarm output while protection active in alarm mode
// - plain arrival immediate on band entry; delayed arrival follows later
// - code 7: overload warning when current exceeds first level
// - first current level shared by overload warning and detect one
// - code plus 1000 selects inverted polarity for every signal
package dso_pkg;

  // clock and the millisecond time base
  localparam int unsigned DSO_CLK_PERIOD_NS = 8;
  localparam int unsigned DSO_MS_NS = 1000000;
  localparam int unsigned DSO_MS_CYCLES = DSO_MS_NS / DSO_CLK_PERIOD_NS;

  // times in milliseconds
  localparam logic [15:0] DSO_LIMIT_DELAY_MS = 16'h0014;
  localparam logic [15:0] DSO_OLP_HOLD_MS = 16'h0064;
  localparam logic [15:0] DSO_CD_HOLD_MS = 16'h0064;

  // heat sink hysteresis in degrees below trip
  localparam logic [8:0] DSO_HS_SET_DEG = 9'h005;
  localparam logic [8:0] DSO_HS_CLR_DEG = 9'h008;

  // current detect release ratio, numerator over denominator
  localparam logic [19:0] DSO_CD_CLR_NUM = 20'h00009;
  localparam logic [19:0] DSO_CD_CLR_DEN = 20'h0000a;

  // terminals and selection codes
  localparam int unsigned DSO_NUM_TERM = 3;
  localparam int unsigned DSO_NUM_CD = 2;
  localparam logic [10:0] DSO_CODE_INVERT = 11'h3e8;
  localparam logic [10:0] DSO_CODE_OVL_WARN = 11'h007;
  localparam logic [10:0] DSO_CODE_READY = 11'h00a;
  localparam logic [10:0] DSO_CODE_ARRIVAL = 11'h001;
  localparam logic [10:0] DSO_CODE_DLY_ARRIVAL = 11'h015;
  localparam logic [10:0] DSO_CODE_DLY_LIMIT = 11'h016;
  localparam logic [10:0] DSO_CODE_HEATSINK = 11'h01c;
  localparam logic [10:0] DSO_CODE_WEAR = 11'h01e;
  localparam logic [10:0] DSO_CODE_REF_LOSS = 11'h021;
  localparam logic [10:0] DSO_CODE_LOW_FREQ = 11'h023;
  localparam logic [10:0] DSO_CODE_OLP = 11'h024;
  localparam logic [10:0] DSO_CODE_CD_ONE = 11'h025;
  localparam logic [10:0] DSO_CODE_CD_TWO = 11'h026;
  localparam logic [10:0] DSO_CODE_MOTOR2 = 11'h031;
  localparam logic [10:0] DSO_CODE_BRAKE = 11'h039;
  localparam logic [10:0] DSO_CODE_ALARM = 11'h063;

  // register byte addresses
  localparam logic [7:0] DSO_ADDR_SEL0 = 8'h00;
  localparam logic [7:0] DSO_ADDR_SEL1 = 8'h04;
  localparam logic [7:0] DSO_ADDR_SEL2 = 8'h08;
  localparam logic [7:0] DSO_ADDR_ARR_BAND = 8'h0c;
  localparam logic [7:0] DSO_ADDR_ARR_DELAY = 8'h10;
  localparam logic [7:0] DSO_ADDR_CD_LEVEL1 = 8'h14;
  localparam logic [7:0] DSO_ADDR_CD_TIMER1 = 8'h18;
  localparam logic [7:0] DSO_ADDR_CD_LEVEL2 = 8'h1c;
  localparam logic [7:0] DSO_ADDR_CD_TIMER2 = 8'h20;
  localparam logic [7:0] DSO_ADDR_TRIP_TEMP = 8'h24;
  localparam logic [7:0] DSO_ADDR_START_FREQ = 8'h28;
  localparam logic [7:0] DSO_ADDR_STATUS = 8'h2c;
  localparam logic [7:0] DSO_ADDR_TERM = 8'h30;

  // register reset values
  localparam logic [10:0] DSO_RST_SEL0 = 11'h00a;
  localparam logic [10:0] DSO_RST_SEL1 = 11'h025;
  localparam logic [10:0] DSO_RST_SEL2 = 11'h063;
  localparam logic [15:0] DSO_RST_ARR_BAND = 16'h00fa;
  localparam logic [15:0] DSO_RST_ARR_DELAY = 16'h0064;
  localparam logic [15:0] DSO_RST_CD_LEVEL = 16'h03e8;
  localparam logic [15:0] DSO_RST_CD_TIMER = 16'h0064;
  localparam logic [7:0] DSO_RST_TRIP_TEMP = 8'h5a;
  localparam logic [15:0] DSO_RST_START_FREQ = 16'h0032;

  // current detect channel states, gray along the path
  typedef enum logic [1:0] {
    DSO_CD_IDLE = 2'b00,
    DSO_CD_TIMING = 2'b01,
    DSO_CD_HOLD = 2'b11,
    DSO_CD_ON = 2'b10
  } dso_cd_state_type;

  // drive state sampled by the block
  typedef struct packed {
    logic hw_ready;
    logic prot_active;
    logic alarm_mode;
    logic running;
    logic dc_brake;
    logic limiting;
    logic olp_active;
    logic cap_life_end;
    logic fan_life_end;
    logic ref_loss;
    logic motor_select_input;
    logic brake_release;
    logic [15:0] out_freq;
    logic [15:0] pre_limit_freq;
    logic [15:0] ref_freq;
    logic [15:0] out_current;
    logic [7:0] heatsink_temp;
  } dso_drive_type;

  // internal status signals, bit 0 is any_alarm_out
  typedef struct packed {
    logic ready_out;
    logic arrival_out;
    logic delayed_arrival_out;
    logic delayed_limiting_out;
    logic heatsink_warn_out;
    logic wear_alarm_out;
    logic ref_loss_out;
    logic low_freq_output_on;
    logic overload_prevention_out;
    logic current_detect_one;
    logic current_detect_two;
    logic overload_warn_out;
    logic second_motor_out;
    logic brake_cmd_out;
    logic any_alarm_out;
  } dso_status_type;

endpackage

// *** src/dso_status_out.sv ***
// drive status output logic: status derivation and terminal routing
`timescale 1ns/10ps
module dso_status_out #(
  parameter int unsigned MS_CYCLES = dso_pkg::DSO_MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // drive state
  input wire dso_pkg::dso_drive_type drive_in,
  // terminals and status
  output logic [dso_pkg::DSO_NUM_TERM-1:0] term_out,
  output dso_pkg::dso_status_type status_out
);
  import dso_pkg::*;

  // absolute difference of two frequencies
  // larger operand first
  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    return (a >= b) ? a - b : b - a;
  endfunction

  // picks one status signal by selection code and applies polarity
  function automatic logic term_value(input logic [10:0] code,
                                      input dso_status_type st);
    logic inv;
    logic [10:0] base;
    logic sig;
    logic valid;

    // strip the offset
    inv = (code >= DSO_CODE_INVERT);
    base = inv ? code - DSO_CODE_INVERT : code;
    sig = 1'b0;
    valid = 1'b1;
    // foreign codes: default
    case (base)
      DSO_CODE_OVL_WARN: sig = st.overload_warn_out;
      DSO_CODE_READY: sig = st.ready_out;
      DSO_CODE_ARRIVAL: sig = st.arrival_out;
      DSO_CODE_DLY_ARRIVAL: sig = st.delayed_arrival_out;
      DSO_CODE_DLY_LIMIT: sig = st.delayed_limiting_out;
      DSO_CODE_HEATSINK: sig = st.heatsink_warn_out;
      DSO_CODE_WEAR: sig = st.wear_alarm_out;
      DSO_CODE_REF_LOSS: sig = st.ref_loss_out;
      DSO_CODE_LOW_FREQ: sig = st.low_freq_output_on;
      DSO_CODE_OLP: sig = st.overload_prevention_out;
      DSO_CODE_CD_ONE: sig = st.current_detect_one;
      DSO_CODE_CD_TWO: sig = st.current_detect_two;
      DSO_CODE_MOTOR2: sig = st.second_motor_out;
      DSO_CODE_BRAKE: sig = st.brake_cmd_out;
      DSO_CODE_ALARM: sig = st.any_alarm_out;
      default: valid = 1'b0;
    endcase

    // unknown codes stay off in both polarities
    return valid & (sig ^ inv);
  endfunction

  // time base, settings
  logic [16:0] tick_cnt_r;
  logic tick_r;
  logic [10:0] sel_r [DSO_NUM_TERM];
  logic [15:0] arr_band_r;
  logic [15:0] arr_delay_r;
  logic [15:0] cd_level_r [DSO_NUM_CD];
  logic [15:0] cd_timer_r [DSO_NUM_CD];
  logic [7:0] trip_temp_r;
  logic [15:0] start_freq_r;

  // ms timers
  logic [15:0] arr_cnt_r;
  logic [15:0] lim_cnt_r;
  logic [15:0] olp_cnt_r;

  // detectors
  logic hs_warn_r;
  logic [DSO_NUM_CD-1:0] cd_on;
  logic arrival_hit;
  logic pre_hit;
  logic [8:0] temp_ext;
  logic [8:0] trip_ext;

  // status and reads
  dso_status_type status_nxt;
  dso_status_type status_r;
  logic [DSO_NUM_TERM-1:0] term_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  // one-cycle enable every millisecond; all timers count in these ticks
  // free running: timers lag a tick
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tick_cnt_r <= 17'h00000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 17'(MS_CYCLES - 1)) begin
      tick_cnt_r <= 17'h00000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
      tick_r <= 1'b0;
    end
  end

  // terminal selectors, one per terminal
  // 11 bits hold inverted codes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sel_r[0] <= DSO_RST_SEL0;
      sel_r[1] <= DSO_RST_SEL1;
      sel_r[2] <= DSO_RST_SEL2;
    end else if (reg_wr) begin
      case (reg_addr)
        DSO_ADDR_SEL0: sel_r[0] <= reg_wdata[10:0];
        DSO_ADDR_SEL1: sel_r[1] <= reg_wdata[10:0];
        DSO_ADDR_SEL2: sel_r[2] <= reg_wdata[10:0];
        default: ;
      endcase
    end
  end

  // detection settings; level one also drives the overload warning
  // timers apply mid-count
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arr_band_r <= DSO_RST_ARR_BAND;
      arr_delay_r <= DSO_RST_ARR_DELAY;
      cd_level_r[0] <= DSO_RST_CD_LEVEL;
      cd_timer_r[0] <= DSO_RST_CD_TIMER;
      cd_level_r[1] <= DSO_RST_CD_LEVEL;
      cd_timer_r[1] <= DSO_RST_CD_TIMER;
      trip_temp_r <= DSO_RST_TRIP_TEMP;
      start_freq_r <= DSO_RST_START_FREQ;
    end else if (reg_wr) begin
      case (reg_addr)
        DSO_ADDR_ARR_BAND: arr_band_r <= reg_wdata;
        DSO_ADDR_ARR_DELAY: arr_delay_r <= reg_wdata;
        DSO_ADDR_CD_LEVEL1: cd_level_r[0] <= reg_wdata;
        DSO_ADDR_CD_TIMER1: cd_timer_r[0] <= reg_wdata;
        DSO_ADDR_CD_LEVEL2: cd_level_r[1] <= reg_wdata;
        DSO_ADDR_CD_TIMER2: cd_timer_r[1] <= reg_wdata;
        DSO_ADDR_TRIP_TEMP: trip_temp_r <= reg_wdata[7:0];
        DSO_ADDR_START_FREQ: start_freq_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // arrival band checks: plain uses output freq, delayed the pre-limit one
  assign arrival_hit =
    abs_diff(drive_in.ref_freq, drive_in.out_freq) <= arr_band_r;
  assign pre_hit =
    abs_diff(drive_in.ref_freq, drive_in.pre_limit_freq) <= arr_band_r;

  // time spent in band; leaving the band restarts the delay
  // saturates, never wraps
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arr_cnt_r <= 16'h0000;
    end else if (!pre_hit) begin
      arr_cnt_r <= 16'h0000;
    end else if (tick_r && arr_cnt_r != 16'hffff) begin
      arr_cnt_r <= arr_cnt_r + 16'h0001;
    end
  end

  // continuous limiting time; any gap restarts it
  // saturates too
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lim_cnt_r <= 16'h0000;
    end else if (!drive_in.limiting) begin
      lim_cnt_r <= 16'h0000;
    end else if (tick_r && lim_cnt_r != 16'hffff) begin
      lim_cnt_r <= lim_cnt_r + 16'h0001;
    end
  end

  // overload prevention hold; reloaded while active so release is late
  // short requests get the full hold
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      olp_cnt_r <= 16'h0000;
    end else if (drive_in.olp_active) begin
      olp_cnt_r <= DSO_OLP_HOLD_MS + 16'h0001;
    end else if (tick_r && olp_cnt_r != 16'h0000) begin
      olp_cnt_r <= olp_cnt_r - 16'h0001;
    end
  end

  // heat sink warning with 3 degree hysteresis, set wins over clear
  // nine bits: sums cannot wrap
  assign temp_ext = {1'b0, drive_in.heatsink_temp};
  assign trip_ext = {1'b0, trip_temp_r};
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hs_warn_r <= 1'b0;
    end else if (temp_ext + DSO_HS_SET_DEG > trip_ext) begin
      hs_warn_r <= 1'b1;
    end else if (temp_ext + DSO_HS_CLR_DEG <= trip_ext) begin
      hs_warn_r <= 1'b0;
    end
  end

  // two independent current detect channels
  genvar g;
  generate
    for (g = 0; g < DSO_NUM_CD; g++) begin : gen_cd
      dso_cd_state_type state_r;
      logic [15:0] cnt_r;
      logic above;
      logic below_clr;
      logic [19:0] cur_scaled;
      logic [19:0] lvl_scaled;

      // compare in 20 bits so the 90 percent scaling cannot overflow
      assign above = drive_in.out_current > cd_level_r[g];
      assign cur_scaled = {4'h0, drive_in.out_current} * DSO_CD_CLR_DEN;
      assign lvl_scaled = {4'h0, cd_level_r[g]} * DSO_CD_CLR_NUM;
      assign below_clr = cur_scaled < lvl_scaled;
      assign cd_on[g] = (state_r == DSO_CD_HOLD) || (state_r == DSO_CD_ON);

      // one counter serves the timer and then the minimum width
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          state_r <= DSO_CD_IDLE;
          cnt_r <= 16'h0000;
        end else begin
          case (state_r)
            DSO_CD_IDLE: begin
              // restart from zero
              cnt_r <= 16'h0000;
              if (above) begin
                state_r <= DSO_CD_TIMING;
              end
            end
            DSO_CD_TIMING: begin
              // more ticks than the timer
              if (!above) begin
                state_r <= DSO_CD_IDLE;
                cnt_r <= 16'h0000;
              end else if (cnt_r > cd_timer_r[g]) begin
                state_r <= DSO_CD_HOLD;
                cnt_r <= DSO_CD_HOLD_MS + 16'h0001;
              end else if (tick_r && cnt_r != 16'hffff) begin
                cnt_r <= cnt_r + 16'h0001;
              end
            end
            DSO_CD_HOLD: begin
              // release is ignored until the minimum width has passed
              if (cnt_r == 16'h0000) begin
                state_r <= DSO_CD_ON;
              end else if (tick_r) begin
                cnt_r <= cnt_r - 16'h0001;
              end
            end
            DSO_CD_ON: begin
              // 90..100 percent holds
              if (below_clr) begin
                state_r <= DSO_CD_IDLE;
              end
            end
            default: begin
              state_r <= DSO_CD_IDLE;
              cnt_r <= 16'h0000;
            end
          endcase
        end
      end
    end
  endgenerate

  // next value of every status signal
  always_comb begin
    status_nxt.ready_out = drive_in.hw_ready &&
                           !drive_in.prot_active;
    status_nxt.arrival_out = arrival_hit;
    status_nxt.delayed_arrival_out = pre_hit &&
                                     (arr_cnt_r >= arr_delay_r);

    // limiting still present
    status_nxt.delayed_limiting_out = drive_in.limiting &&
                                      (lim_cnt_r > DSO_LIMIT_DELAY_MS);
    status_nxt.heatsink_warn_out = hs_warn_r;
    status_nxt.wear_alarm_out = drive_in.cap_life_end ||
                                drive_in.fan_life_end;
    status_nxt.ref_loss_out = drive_in.ref_loss;
    status_nxt.low_freq_output_on =
      (drive_in.running && drive_in.out_freq <= start_freq_r) ||
      drive_in.dc_brake;

    // on now, hold covers the tail
    status_nxt.overload_prevention_out = drive_in.olp_active ||
                                         (olp_cnt_r != 16'h0000);
    status_nxt.current_detect_one = cd_on[0];
    status_nxt.current_detect_two = cd_on[1];
    // shares level one with current detect one
    status_nxt.overload_warn_out =
      drive_in.out_current > cd_level_r[0];
    status_nxt.second_motor_out = drive_in.motor_select_input;
    status_nxt.brake_cmd_out = drive_in.brake_release;
    status_nxt.any_alarm_out = drive_in.prot_active &&
                               drive_in.alarm_mode;
  end

  // status register
  // one cycle behind drive_in
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // terminal routing from the same next value, so terminals and status agree
  // reset sits low, inverted too
  generate
    for (g = 0; g < DSO_NUM_TERM; g++) begin : gen_term
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          term_r[g] <= 1'b0;
        end else begin
          term_r[g] <= term_value(sel_r[g], status_nxt);
        end
      end
    end
  endgenerate

  // read decode; unmapped addresses read zero
  // read-only views at the end
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_addr)
      DSO_ADDR_SEL0: rdata_nxt = {5'h00, sel_r[0]};
      DSO_ADDR_SEL1: rdata_nxt = {5'h00, sel_r[1]};
      DSO_ADDR_SEL2: rdata_nxt = {5'h00, sel_r[2]};
      DSO_ADDR_ARR_BAND: rdata_nxt = arr_band_r;
      DSO_ADDR_ARR_DELAY: rdata_nxt = arr_delay_r;
      DSO_ADDR_CD_LEVEL1: rdata_nxt = cd_level_r[0];
      DSO_ADDR_CD_TIMER1: rdata_nxt = cd_timer_r[0];
      DSO_ADDR_CD_LEVEL2: rdata_nxt = cd_level_r[1];
      DSO_ADDR_CD_TIMER2: rdata_nxt = cd_timer_r[1];
      DSO_ADDR_TRIP_TEMP: rdata_nxt = {8'h00, trip_temp_r};
      DSO_ADDR_START_FREQ: rdata_nxt = start_freq_r;
      DSO_ADDR_STATUS: rdata_nxt = {1'b0, status_r};
      DSO_ADDR_TERM: rdata_nxt = {13'h0000, term_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  // zero outside the read cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // outputs are registers
  assign reg_rdata = rdata_r;
  assign term_out = term_r;
  assign status_out = status_r;

endmodule

// *** tb/dso_status_out_chk.sv ***
// assertion checker for the drive status output block
`timescale 1ns/10ps
module dso_status_out_chk #(
  parameter int unsigned MS_CYCLES = 10
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // drive state and status
  input wire dso_pkg::dso_drive_type drive_in,
  input wire dso_pkg::dso_status_type status_out
);
  import dso_pkg::*;
  localparam int unsigned HOLD_C = 100 * MS_CYCLES;
  localparam int unsigned LIM_C = 20 * MS_CYCLES;
  logic [31:0] olp_cnt_r;
  logic [31:0] cd_cnt_r;
  logic [31:0] lim_cnt_r;
  default clocking dflt_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // run lengths; on-times are checked when the output falls
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      olp_cnt_r <= 32'h0;
      cd_cnt_r <= 32'h0;
      lim_cnt_r <= 32'h0;
    end else begin
      olp_cnt_r <= status_out.overload_prevention_out ? olp_cnt_r + 1 : 0;
      cd_cnt_r <= status_out.current_detect_one ? cd_cnt_r + 1 : 0;
      lim_cnt_r <= drive_in.limiting ? lim_cnt_r + 1 : 0;
    end
  end
  ready_out_a: assert property ($past(rst_b) |->
    status_out.ready_out == $past(drive_in.hw_ready && !drive_in.prot_active))
    else $error("ready output wrong");
  any_alarm_a: assert property (
    drive_in.prot_active && drive_in.alarm_mode |=> status_out.any_alarm_out)
    else $error("alarm output missing");
  wear_out_a: assert property ($past(rst_b) |->
    status_out.wear_alarm_out ==
    $past(drive_in.cap_life_end || drive_in.fan_life_end))
    else $error("wear alarm wrong");
  motor_sel_a: assert property (
    $rose(drive_in.motor_select_input) |=> status_out.second_motor_out)
    else $error("second motor output missing");
  brake_off_a: assert property (
    !drive_in.brake_release |=> !status_out.brake_cmd_out)
    else $error("brake command wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  olp_on_a: assert property (
    drive_in.olp_active |=> status_out.overload_prevention_out)
    else $error("overload prevention output missing");
  olp_hold_a: assert property (
    $fell(status_out.overload_prevention_out) |-> olp_cnt_r >= HOLD_C)
    else $error("overload prevention pulse too short");
  cd_hold_a: assert property (
    $fell(status_out.current_detect_one) |-> cd_cnt_r >= HOLD_C)
    else $error("current detect pulse too short");
  limit_delay_a: assert property (
    $rose(status_out.delayed_limiting_out) |-> $past(lim_cnt_r) >= LIM_C)
    else $error("limiting output too early");
  cover property ($fell(status_out.current_detect_one));
  cover property ($fell(status_out.overload_prevention_out));
  cover property ($rose(status_out.delayed_limiting_out));
endmodule
bind dso_status_out dso_status_out_chk #(.MS_CYCLES(MS_CYCLES))
  dso_status_out_chk_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .drive_in(drive_in), .status_out(status_out));

// *** tb/dso_term_watch.sv ***
// far-side model: equipment latching the terminal levels
`timescale 1ns/10ps
module dso_term_watch (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // terminals from the block
  input wire logic [2:0] term_in,
  // latched view and rising edges seen on terminal 0
  output logic [2:0] seen_r,
  output logic [15:0] rise_cnt_r
);
  // sampled once a clock, like a plc input scan
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      seen_r <= 3'h0;
      rise_cnt_r <= 16'h0000;
    end else begin
      seen_r <= term_in;
      if (term_in[0] && !seen_r[0]) begin
        rise_cnt_r <= rise_cnt_r + 16'h0001;
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the drive status output block
`timescale 1ns/10ps
module tb_top;
  import dso_pkg::*;
  localparam int unsigned MS = 10;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] reg_rdata;
  dso_drive_type drv = '0;
  logic [2:0] term_out;
  dso_status_type status_out;
  logic [2:0] seen;
  logic [15:0] rises;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h0b2f89b9;
  logic hs;
  logic e;
  logic [15:0] r0;
  int errors = 0;
  int checks_done = 0;
  int i;
  logic [15:0] rst_tab [0:10] = '{DSO_RST_SEL0, DSO_RST_SEL1, DSO_RST_SEL2,
    DSO_RST_ARR_BAND, DSO_RST_ARR_DELAY, DSO_RST_CD_LEVEL, DSO_RST_CD_TIMER,
    DSO_RST_CD_LEVEL, DSO_RST_CD_TIMER, DSO_RST_TRIP_TEMP, DSO_RST_START_FREQ};
  logic [10:0] code_tab [0:7] = '{DSO_CODE_READY, DSO_CODE_WEAR,
    DSO_CODE_REF_LOSS, DSO_CODE_LOW_FREQ, DSO_CODE_MOTOR2, DSO_CODE_BRAKE,
    DSO_CODE_ALARM, DSO_CODE_OVL_WARN};
  logic [7:0] row0 = 8'h9b;

  initial forever #4 ref_clk = ~ref_clk;

  dso_status_out #(.MS_CYCLES(MS)) dso_status_out_i (.ref_clk(ref_clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_in(drv), .term_out(term_out), .status_out(status_out));
  dso_term_watch dso_term_watch_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .term_in(term_out), .seen_r(seen), .rise_cnt_r(rises));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] sv, input logic [15:0] ev);
    checks_done++;
    if (sv !== ev) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, sv, ev);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // expected value is queued before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [15:0] ev);
    exp_q.push_back(ev);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic sel(input logic [10:0] a, b, c);
    wr(DSO_ADDR_SEL0, 16'(a));
    wr(DSO_ADDR_SEL1, 16'(b));
    wr(DSO_ADDR_SEL2, 16'(c));
  endtask
  task automatic term(input logic [2:0] ev);
    wt(2);
    rd(DSO_ADDR_TERM, {13'h0000, ev});
    chk({13'h0000, seen}, {13'h0000, ev});
  endtask
  // complementary drive states for the level signals
  task automatic row(input logic p);
    drv.prot_active <= p;
    drv.ref_loss <= p;
    drv.brake_release <= p;
    drv.cap_life_end <= !p;
    drv.motor_select_input <= !p;
    drv.out_freq <= p ? 16'h0100 : 16'h0000;
    drv.out_current <= p ? 16'h0000 : 16'h0400;
  endtask

  // read data stand one cycle only, so compare mid-cycle
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) errors++;
      else chk(reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    end_sim();
  end

  initial begin
    wt(5);
    rst_b <= 1'b1;
    drv.ref_freq <= 16'h1000;
    // reset values, unmapped and read-only places
    for (i = 0; i < 11; i++) rd(8'(i * 4), rst_tab[i]);
    rd(8'h34, 16'h0000);
    wr(DSO_ADDR_STATUS, 16'hffff);
    rd(DSO_ADDR_STATUS, 16'h0000);
    wr(DSO_ADDR_SEL2, 16'hffff);
    rd(DSO_ADDR_SEL2, 16'h07ff);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(DSO_ADDR_ARR_BAND, seed[15:0]);
      rd(DSO_ADDR_ARR_BAND, seed[15:0]);
    end
    wr(DSO_ADDR_ARR_BAND, DSO_RST_ARR_BAND);
    // eight level signals, plain and inverted, in both states
    drv.hw_ready <= 1'b1;
    drv.alarm_mode <= 1'b1;
    drv.running <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      row(p[0]);
      for (i = 0; i < 8; i++) begin
        sel(code_tab[i], code_tab[i] + DSO_CODE_INVERT, code_tab[i]);
        e = row0[i] ^ p[0];
        term({e, !e, e});
      end
    end
    // arrival at the band edge; delayed copy follows pre-limit frequency
    wr(DSO_ADDR_ARR_DELAY, 16'h0005);
    sel(DSO_CODE_ARRIVAL, DSO_CODE_DLY_ARRIVAL,
      DSO_CODE_DLY_ARRIVAL + DSO_CODE_INVERT);
    drv.out_freq <= 16'h1000 - DSO_RST_ARR_BAND;
    drv.pre_limit_freq <= 16'h0000;
    wt(80);
    term(3'b101);
    drv.pre_limit_freq <= 16'h1000 + DSO_RST_ARR_BAND;
    term(3'b101);
    wt(70);
    term(3'b011);
    // limiting shorter than the delay must not show
    sel(DSO_CODE_DLY_LIMIT, 11'h005, DSO_CODE_DLY_LIMIT + DSO_CODE_INVERT);
    drv.limiting <= 1'b1;
    wt(15 * MS);
    drv.limiting <= 1'b0;
    term(3'b100);
    drv.limiting <= 1'b1;
    wt(18 * MS);
    term(3'b100);
    wt(6 * MS);
    term(3'b001);
    drv.limiting <= 1'b0;
    // a one-cycle prevention request still gives the full pulse
    sel(DSO_CODE_OLP, DSO_CODE_OLP + DSO_CODE_INVERT, DSO_CODE_OLP);
    r0 = rises;
    drv.olp_active <= 1'b1;
    wt(1);
    drv.olp_active <= 1'b0;
    term(3'b101);
    wt(95 * MS);
    term(3'b101);
    wt(8 * MS);
    term(3'b010);
    chk(rises, r0 + 16'h0001);
    // heat sink hysteresis against a random temperature walk
    sel(DSO_CODE_HEATSINK, DSO_CODE_HEATSINK + DSO_CODE_INVERT, 11'h005);
    hs = 1'b0;
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      drv.heatsink_temp <= 8'h50 + {4'h0, seed[3:0]};
      if (8'h55 + seed[3:0] > DSO_RST_TRIP_TEMP) hs = 1'b1;
      else if (8'h58 + seed[3:0] <= DSO_RST_TRIP_TEMP) hs = 1'b0;
      term({1'b0, !hs, hs});
    end
    // two detect channels; level one also moves the overload warning
    wr(DSO_ADDR_CD_LEVEL1, 16'h0100);
    wr(DSO_ADDR_CD_TIMER1, 16'h0002);
    wr(DSO_ADDR_CD_LEVEL2, 16'h0800);
    wr(DSO_ADDR_CD_TIMER2, 16'h0002);
    sel(DSO_CODE_CD_ONE, DSO_CODE_CD_TWO, DSO_CODE_OVL_WARN);
    drv.out_current <= 16'h0200;
    term(3'b100);
    wt(4 * MS);
    term(3'b101);
    drv.out_current <= 16'h00f0;
    term(3'b001);
    drv.out_current <= 16'h00e0;
    term(3'b001);
    wt(110 * MS);
    term(3'b000);
    drv.out_current <= 16'h0900;
    wt(4 * MS);
    term(3'b111);
    // a second reset restores the selectors
    rst_b <= 1'b0;
    wt(2);
    rst_b <= 1'b1;
    rd(DSO_ADDR_SEL0, 16'(DSO_RST_SEL0));
    wt(3);
    end_sim();
  end
endmodule
